// ===== src/sbc_mode_pkg.sv
// constants, types and carriers for the device and CAN mode controller
// assumes a 50 MHz mclk; pin inputs arrive unsynchronised
package sbc_mode_pkg;
  localparam int CLK_PERIOD_NS = 20;

  // register map, 7-bit addresses
  localparam logic [6:0] DEV_CTRL_ADDR   = 7'h01;
  localparam logic [6:0] DEV_STATUS_ADDR = 7'h03;
  localparam logic [6:0] CAN_CTRL_ADDR   = 7'h20;
  localparam logic [7:0] DEV_CTRL_RESET   = 8'h24;
  localparam logic [7:0] DEV_STATUS_RESET = 8'h01;
  localparam logic [7:0] CAN_CTRL_RESET   = 8'h41;

  // control field positions
  localparam int RESET_WAKE_BIT = 5;
  localparam int OV_OFF_BIT     = 4;
  localparam int AUX_UV_BIT     = 3;
  // status field positions
  localparam int CAUSE_BIT   = 7;
  localparam int PREWARN_BIT = 6;
  localparam int PWRUP_BIT   = 5;
  localparam int SUPPLY_BIT  = 0;

  // mode select encodings
  localparam logic [2:0] DMODE_SLEEP   = 3'h1;
  localparam logic [2:0] DMODE_STANDBY = 3'h4;
  localparam logic [2:0] DMODE_NORMAL  = 3'h7;
  localparam logic [1:0] CMODE_STBY    = 2'h0;
  localparam logic [1:0] CMODE_NORMAL  = 2'h1;
  localparam logic [1:0] CMODE_SILENT  = 2'h3;

  // timing: filter is a least time, so it rounds up
  localparam int FILTER_TIME_NS = 1000;
  localparam int FILTER_CYCLES  = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FW             = $clog2(FILTER_CYCLES);
  localparam logic [FW-1:0] FILTER_LAST = FW'(FILTER_CYCLES - 1);
  localparam int SILENCE_TIME_US = 1000;
  localparam int SILENCE_CYCLES  = SILENCE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int RESET_TIME_US   = 4;
  localparam int RESET_CYCLES    = (RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESET_LAST = 8'(RESET_CYCLES - 1);

  typedef enum logic [2:0] {
    DEV_OFF, DEV_RESET, DEV_STANDBY, DEV_NORMAL, DEV_SLEEP
  } dev_state_t;

  typedef enum logic [2:0] {
    CAN_OFF, CAN_STBY, CAN_BIASED, CAN_NORMAL, CAN_SILENT
  } can_state_t;

  // asynchronous pins and comparator outputs
  typedef struct packed {
    logic spiClk;
    logic spiCsN;
    logic spiMosi;
    logic vsPowerOk;
    logic vsUvTrx;
    logic canOvertemp;
    logic canTempOk;
    logic vccOvervolt;
    logic vccLowTrx;
    logic auxUndervolt;
    logic thermalHigh;
    logic busDominant;
    logic localWake;
    logic interruptEvent;
    logic linWake;
    logic linStandby;
  } pins_t;

  // settings held in neighbouring registers, same clock
  typedef struct packed {
    logic thermalPrewarnEnable;
    logic canWakeEnable;
    logic externalWakeEnable;
    logic anySourceEnabled;
  } wake_cfg_t;

  // one-cycle clear pulses: {interrupt, lin, can}
  typedef struct packed {
    logic intClear;
    logic linClear;
    logic canClear;
  } flag_clear_t;
endpackage : sbc_mode_pkg

// ===== src/device_can_mode_control.sv
// device operating mode and CAN transceiver mode control with SPI registers
// assumes pins are asynchronous; cfg and clear inputs are on mclk
`timescale 1ns/1ps
module device_can_mode_control
  import sbc_mode_pkg::*;
#(
  parameter int   SILENCE_LIMIT     = sbc_mode_pkg::SILENCE_CYCLES,
  parameter logic RESET_WAKE_OPTION = 1'b1
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire sbc_mode_pkg::pins_t       pins,
  input  wire sbc_mode_pkg::wake_cfg_t   cfg,
  input  wire sbc_mode_pkg::flag_clear_t flagClear,
  output logic                           spiMiso,
  output logic                           canRxd,
  output sbc_mode_pkg::dev_state_t       devMode,
  output sbc_mode_pkg::can_state_t       canMode,
  output logic [2:0]                     wakeFlags,
  output logic                           regulatorOn
);
  import sbc_mode_pkg::*;

  localparam int SW = $clog2(SILENCE_LIMIT + 1);
  localparam logic [SW-1:0] SIL_MAX = SW'(SILENCE_LIMIT);

  function automatic logic [2:0] modeCode(input dev_state_t s);
    unique case (s)
      DEV_NORMAL: modeCode = DMODE_NORMAL;
      DEV_SLEEP:  modeCode = DMODE_SLEEP;
      default:    modeCode = DMODE_STANDBY;
    endcase
  endfunction : modeCode

  pins_t      pinMeta_reg;
  pins_t      pinSync_reg;
  logic       sckPrev_reg;
  logic       auxPrev_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shiftIn_reg;
  logic [7:0] shiftOut_reg;
  logic [6:0] addr_reg;
  logic       rnw_reg;
  logic       spiMiso_reg;
  logic       resetWake_reg;
  logic       ovOff_reg;
  logic       auxUv_reg;
  logic [6:0] canCtrl_reg;
  logic       cause_reg;
  logic       prewarn_reg;
  logic       pwrUp_reg;
  logic       supplyLow_reg;
  logic [7:0] resetCnt_reg;
  logic [2:0] flags_reg;
  logic [SW-1:0] silCnt_reg;
  logic [1:0]    wpStage_reg;
  logic [FW-1:0] wpCnt_reg;
  logic          canRxd_reg;
  logic          regOn_reg;
  dev_state_t    devState_reg;
  dev_state_t    devState_next;
  can_state_t    canState_reg;
  can_state_t    canState_next;

  // pin synchroniser; only the second stage is read
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
    end else begin
      pinMeta_reg <= pins;
      pinSync_reg <= pinMeta_reg;
    end
  end

  wire pins_t p = pinSync_reg;

  // spi slave, mode 0, frame {addr[6:0], rnw} then data
  wire       csActive    = ~p.spiCsN;
  wire       sckRise     = csActive & p.spiClk & ~sckPrev_reg;
  wire       sckFall     = csActive & ~p.spiClk & sckPrev_reg;
  wire [7:0] writeData   = {shiftIn_reg[6:0], p.spiMosi};
  wire       writeStrobe = sckRise & (bitCnt_reg == 4'hf) & ~rnw_reg;
  wire       ctrlWrite   = writeStrobe & (addr_reg == DEV_CTRL_ADDR);
  wire       canWrite    = writeStrobe & (addr_reg == CAN_CTRL_ADDR);
  wire       resetWake   = RESET_WAKE_OPTION ? resetWake_reg : 1'b1;

  // reserved bits read zero and are never stored
  wire [7:0] ctrlRead   = {2'h0, resetWake, ovOff_reg, auxUv_reg, modeCode(devState_reg)};
  wire [7:0] statusRead = {cause_reg, prewarn_reg, pwrUp_reg, 4'h0, supplyLow_reg};
  wire [7:0] canRead    = {1'b0, canCtrl_reg[6:4], 2'h0, canCtrl_reg[1:0]};
  wire [7:0] readData   = (addr_reg == DEV_CTRL_ADDR)   ? ctrlRead :
                          (addr_reg == DEV_STATUS_ADDR) ? statusRead :
                          (addr_reg == CAN_CTRL_ADDR)   ? canRead : 8'h00;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sckPrev_reg  <= 1'b0;
      bitCnt_reg   <= 4'h0;
      shiftIn_reg  <= 8'h00;
      shiftOut_reg <= 8'h00;
      addr_reg     <= 7'h00;
      rnw_reg      <= 1'b0;
      spiMiso_reg  <= 1'b0;
    end else begin
      sckPrev_reg <= p.spiClk;
      if (!csActive) begin
        bitCnt_reg <= 4'h0;
      end else if (sckRise) begin
        shiftIn_reg <= writeData;
        bitCnt_reg  <= bitCnt_reg + 4'h1;
        if (bitCnt_reg == 4'h7) begin
          addr_reg <= shiftIn_reg[6:0];
          rnw_reg  <= p.spiMosi;
        end
      end
      if (sckFall && bitCnt_reg == 4'h8) begin
        spiMiso_reg  <= rnw_reg & readData[7];
        shiftOut_reg <= rnw_reg ? {readData[6:0], 1'b0} : 8'h00;
      end else if (sckFall) begin
        spiMiso_reg  <= shiftOut_reg[7];
        shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
      end
    end
  end

  // mode commands, decoded in the write cycle
  wire cmdNormal  = ctrlWrite & (writeData[2:0] == DMODE_NORMAL);
  wire cmdSleep   = ctrlWrite & (writeData[2:0] == DMODE_SLEEP);
  wire cmdStandby = ctrlWrite & ~cmdNormal & ~cmdSleep;
  wire ovTrip     = p.vccOvervolt & ovOff_reg;
  wire sleepOk    = (flags_reg == 3'h0) & cfg.anySourceEnabled;
  wire auxFall    = auxPrev_reg & ~p.auxUndervolt;
  wire canWakeDet;
  wire wakeIn     = p.localWake | p.interruptEvent | p.linWake | canWakeDet;
  // aux undervoltage release counts as a wake only with external wake
  wire sleepWake  = wakeIn | (~auxUv_reg & auxFall & cfg.externalWakeEnable);
  wire auxReset   = auxUv_reg & p.auxUndervolt;
  wire dev_state_t wakeTarget = resetWake ? DEV_RESET : DEV_STANDBY;

  always_comb begin
    devState_next = devState_reg;
    unique case (devState_reg)
      DEV_OFF:
        if (p.vsPowerOk) devState_next = DEV_STANDBY;
      DEV_RESET:
        if (ovTrip) devState_next = DEV_SLEEP;
        else if (resetCnt_reg == RESET_LAST) devState_next = DEV_STANDBY;
      DEV_STANDBY:
        if (ovTrip) devState_next = DEV_SLEEP;
        else if (cmdNormal) devState_next = DEV_NORMAL;
        else if (cmdSleep && sleepOk) devState_next = DEV_SLEEP;
      DEV_NORMAL:
        if (ovTrip) devState_next = DEV_SLEEP;
        else if (cmdSleep && sleepOk) devState_next = DEV_SLEEP;
        else if (cmdStandby || cmdSleep) devState_next = DEV_STANDBY;
      DEV_SLEEP:
        if (auxReset) devState_next = DEV_RESET;
        else if (sleepWake) devState_next = wakeTarget;
        else if (cmdStandby) devState_next = DEV_STANDBY;
    endcase
    if (!p.vsPowerOk) devState_next = DEV_OFF;
  end

  wire enterSleep = (devState_next == DEV_SLEEP) & (devState_reg != DEV_SLEEP);
  wire enterNorm  = (devState_next == DEV_NORMAL) & (devState_reg != DEV_NORMAL);
  wire powerUp    = (devState_reg == DEV_OFF) & (devState_next != DEV_OFF);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      devState_reg  <= DEV_OFF;
      auxPrev_reg   <= 1'b0;
      resetCnt_reg  <= 8'h00;
      resetWake_reg <= DEV_CTRL_RESET[RESET_WAKE_BIT];
      ovOff_reg     <= DEV_CTRL_RESET[OV_OFF_BIT];
      auxUv_reg     <= DEV_CTRL_RESET[AUX_UV_BIT];
      canCtrl_reg   <= CAN_CTRL_RESET[6:0];
      regOn_reg     <= 1'b0;
    end else begin
      devState_reg <= devState_next;
      auxPrev_reg  <= p.auxUndervolt;
      // reset timer clears to zero while aux supply is low
      resetCnt_reg <= (devState_reg == DEV_RESET && !p.auxUndervolt) ?
                      resetCnt_reg + 8'h01 : 8'h00;
      if (ctrlWrite) begin
        resetWake_reg <= writeData[RESET_WAKE_BIT];
        ovOff_reg     <= writeData[OV_OFF_BIT];
        auxUv_reg     <= writeData[AUX_UV_BIT];
      end
      if (canWrite) begin
        canCtrl_reg <= {writeData[6:4], 2'h0, writeData[1:0]};
      end
      regOn_reg <= (devState_next != DEV_OFF) & (devState_next != DEV_SLEEP);
    end
  end

  // status flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cause_reg     <= DEV_STATUS_RESET[CAUSE_BIT];
      prewarn_reg   <= DEV_STATUS_RESET[PREWARN_BIT];
      pwrUp_reg     <= DEV_STATUS_RESET[PWRUP_BIT];
      supplyLow_reg <= DEV_STATUS_RESET[SUPPLY_BIT];
    end else begin
      if (enterSleep) cause_reg <= ovTrip;
      if (cfg.thermalPrewarnEnable) prewarn_reg <= p.thermalHigh;
      if (powerUp) pwrUp_reg <= 1'b1;
      else if (enterNorm) pwrUp_reg <= 1'b0;
      supplyLow_reg <= p.vccLowTrx;
    end
  end

  // event flags, set wins over clear
  wire [2:0] flagSet = {p.interruptEvent, p.linWake & p.linStandby, canWakeDet};
  wire [2:0] flagClr = {flagClear.intClear, flagClear.linClear, flagClear.canClear};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_reg <= 3'h0;
    end else begin
      flags_reg <= flagSet | (flags_reg & ~flagClr);
    end
  end

  // can transceiver mode machine
  wire       busDom     = p.busDominant;
  wire       busSilent  = (silCnt_reg == SIL_MAX);
  wire [1:0] can_mode_select       = canCtrl_reg[1:0];
  wire       devNormal  = (devState_reg == DEV_NORMAL);
  wire       forceOff   = (devState_reg == DEV_OFF) | ~p.vsPowerOk | p.vsUvTrx |
                          p.canOvertemp;
  // biased standby has no code of its own
  wire       wantActive = devNormal & ((can_mode_select == CMODE_NORMAL) | (can_mode_select == CMODE_SILENT));
  wire can_state_t activeMode = (can_mode_select == CMODE_NORMAL) ? CAN_NORMAL : CAN_SILENT;
  wire can_state_t lowMode    = busSilent ? CAN_STBY : CAN_BIASED;

  always_comb begin
    canState_next = canState_reg;
    unique case (canState_reg)
      CAN_OFF:
        if (p.canTempOk) canState_next = CAN_STBY;
      CAN_STBY:
        if (wantActive) canState_next = activeMode;
        else if (busDom) canState_next = CAN_BIASED;
      CAN_BIASED:
        if (wantActive) canState_next = activeMode;
        else if (busSilent) canState_next = CAN_STBY;
      CAN_NORMAL, CAN_SILENT:
        canState_next = wantActive ? activeMode : lowMode;
    endcase
    if (forceOff) canState_next = CAN_OFF;
  end

  // wake pattern: dominant, recessive, dominant, each held a filter time
  wire wpOn     = cfg.canWakeEnable &
                  ((canState_reg == CAN_STBY) | (canState_reg == CAN_BIASED));
  wire levelOk  = (busDom == ~wpStage_reg[0]);
  wire phaseEnd = wpOn & levelOk & (wpCnt_reg == FILTER_LAST);
  assign canWakeDet = phaseEnd & (wpStage_reg == 2'h2);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      canState_reg <= CAN_OFF;
      silCnt_reg   <= '0;
      wpStage_reg  <= 2'h0;
      wpCnt_reg    <= '0;
      canRxd_reg   <= 1'b1;
    end else begin
      canState_reg <= canState_next;
      if (busDom) silCnt_reg <= '0;
      else if (!busSilent) silCnt_reg <= silCnt_reg + SW'(1);
      if (!wpOn || canWakeDet) begin
        wpStage_reg <= 2'h0;
        wpCnt_reg   <= '0;
      end else if (!levelOk) begin
        wpCnt_reg <= '0;
      end else if (phaseEnd) begin
        wpStage_reg <= wpStage_reg + 2'h1;
        wpCnt_reg   <= '0;
      end else begin
        wpCnt_reg <= wpCnt_reg + FW'(1);
      end
      unique case (canState_reg)
        CAN_OFF:                canRxd_reg <= 1'b1;
        CAN_STBY, CAN_BIASED:   canRxd_reg <= ~flags_reg[0];
        CAN_NORMAL, CAN_SILENT: canRxd_reg <= ~busDom;
      endcase
    end
  end

  assign spiMiso     = spiMiso_reg;
  assign canRxd      = canRxd_reg;
  assign devMode     = devState_reg;
  assign canMode     = canState_reg;
  assign wakeFlags   = flags_reg;
  assign regulatorOn = regOn_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_NORMAL_FROM_CMD: assert property (
    $rose(devState_reg == DEV_NORMAL) |->
      $past(devState_reg) == DEV_STANDBY && $past(cmdNormal))
    else $error("normal entered without command");
  AST_FLAG_SET_WINS: assert property (
    flagSet != 3'h0 |=> (flags_reg & $past(flagSet)) == $past(flagSet))
    else $error("event flag lost");
  AST_UNDEF_STANDBY: assert property (
    devNormal && cmdStandby && !ovTrip && p.vsPowerOk |=> devState_reg == DEV_STANDBY)
    else $error("undefined code did not give standby");
  AST_OV_SLEEP: assert property (
    ovTrip && p.vsPowerOk && devState_reg != DEV_OFF && devState_reg != DEV_SLEEP
      |=> devState_reg == DEV_SLEEP && cause_reg && !regulatorOn)
    else $error("overvoltage did not force sleep");
  AST_AUX_RESET: assert property (
    devState_reg == DEV_SLEEP && auxReset && p.vsPowerOk |=> devState_reg == DEV_RESET)
    else $error("aux undervoltage ignored");
  AST_PWRUP_CLEAR: assert property (
    devNormal |-> !pwrUp_reg)
    else $error("power-up flag set in normal");
  AST_LOWPOWER_CAN: assert property (
    !devNormal && !$past(devNormal) && canState_reg != CAN_OFF |->
      canState_reg == CAN_STBY || canState_reg == CAN_BIASED)
    else $error("transceiver active outside normal");
  AST_FORCE_OFF: assert property (
    forceOff |=> canState_reg == CAN_OFF)
    else $error("transceiver not off");
  AST_RXD_OFF: assert property (
    canState_reg == CAN_OFF && $past(canState_reg) == CAN_OFF |-> canRxd)
    else $error("rxd low in off");
  AST_SILENCE_STBY: assert property (
    canState_reg == CAN_BIASED && busSilent && !wantActive && !forceOff
      |=> canState_reg == CAN_STBY)
    else $error("no return to standby after silence");
  AST_WAKE_RXD: assert property (
    canWakeDet && !flagClear.canClear |=> flags_reg[0] ##1 (!canRxd || !wpOn))
    else $error("wake pattern not signalled");

  COV_NORMAL: cover property ($rose(devState_reg == DEV_NORMAL));
  COV_OV_SLEEP: cover property (enterSleep && ovTrip);
  COV_CAN_WAKE: cover property (canWakeDet);
  COV_CAN_NORMAL: cover property ($rose(canState_reg == CAN_NORMAL));
endmodule : device_can_mode_control

// ===== verif/spi_host_model.sv
// host side of the serial register bus, mode 0, msb first, 16-bit frames
// assumes mclk is the design clock; half period of 5 mclk keeps the sync margin
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic mclk,
  output logic      spiClk,
  output logic      spiCsN,
  output logic      spiMosi,
  input  wire logic spiMiso
);
  initial begin
    spiClk  = 1'b0;
    spiCsN  = 1'b1;
    spiMosi = 1'b0;
  end

  task automatic half();
    repeat (5) @(posedge mclk);
  endtask : half

  task automatic xfer(input logic [6:0] addr, input logic rnw, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {addr, rnw, wdata};
    rdata = 8'h00;
    @(posedge mclk);
    spiCsN <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spiMosi <= frame[i];
      half();
      spiClk <= 1'b1;
      if (i < 8) begin
        rdata[i] = spiMiso;
      end
      half();
      spiClk <= 1'b0;
    end
    half();
    spiCsN <= 1'b1;
    // released line must not look like held data
    spiMosi <= ~spiMosi;
    repeat (8) @(posedge mclk);
  endtask : xfer
endmodule : spi_host_model

// ===== verif/device_can_mode_control_test.sv
// self-checking bench for device_can_mode_control
// assumes spi_host_model drives the serial pins; all other pins come from here
`timescale 1ns/1ps
module device_can_mode_control_test;
  import sbc_mode_pkg::*;
  localparam int WAKE_INT   = 2;
  localparam int WAKE_LOCAL = 3;
  logic        mclk;
  logic        rst;
  pins_t       env;
  pins_t       pinsIn;
  wake_cfg_t   cfg;
  flag_clear_t flagClear;
  logic        spiClk;
  logic        spiCsN;
  logic        spiMosi;
  logic        spiMiso;
  logic        canRxd;
  dev_state_t  devMode;
  can_state_t  canMode;
  logic [2:0]  wakeFlags;
  logic        regulatorOn;
  int          failCount = 0;
  int          samplesChecked = 0;
  logic [1:0]  copmTab [3] = '{CMODE_NORMAL, CMODE_SILENT, CMODE_STBY};
  can_state_t  canTab  [3] = '{CAN_NORMAL, CAN_SILENT, CAN_STBY};

  assign pinsIn = {spiClk, spiCsN, spiMosi, env[12:0]};

  spi_host_model u_spi_host_model (
    .mclk    (mclk),
    .spiClk  (spiClk),
    .spiCsN  (spiCsN),
    .spiMosi (spiMosi),
    .spiMiso (spiMiso)
  );

  // short silence timeout keeps the run brief
  device_can_mode_control #(
    .SILENCE_LIMIT (20)
  ) u_device_can_mode_control (
    .mclk        (mclk),
    .rst         (rst),
    .pins        (pinsIn),
    .cfg         (cfg),
    .flagClear   (flagClear),
    .spiMiso     (spiMiso),
    .canRxd      (canRxd),
    .devMode     (devMode),
    .canMode     (canMode),
    .wakeFlags   (wakeFlags),
    .regulatorOn (regulatorOn)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic results();
    if (failCount == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] junk;
    u_spi_host_model.xfer(a, 1'b0, d, junk);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] got;
    u_spi_host_model.xfer(a, 1'b1, 8'h00, got);
    check("spiRead", got, exp);
  endtask : rd

  task automatic devIs(input dev_state_t e);
    check("devMode", 8'(devMode), 8'(e));
  endtask : devIs

  task automatic canIs(input can_state_t e);
    check("canMode", 8'(canMode), 8'(e));
  endtask : canIs

  task automatic clr();
    flagClear <= 3'b111;
    tick(1);
    flagClear <= 3'b000;
    tick(1);
  endtask : clr

  // level held past the two sync flops, then flags cleared for the next sleep
  task automatic pulse(input int b);
    env[b] <= 1'b1;
    tick(6);
    env[b] <= 1'b0;
    tick(4);
    clr();
  endtask : pulse

  // dominant, recessive, dominant, each past the filter time
  task automatic wup();
    for (int i = 0; i < 3; i++) begin
      env.busDominant <= (i != 1);
      tick(60);
    end
    env.busDominant <= 1'b0;
    tick(6);
  endtask : wup

  initial begin
    rst = 1'b1;
    env = '0;
    cfg = '0;
    flagClear = '0;
    env.vsPowerOk = 1'b1;
    env.canTempOk = 1'b1;
    env.vccLowTrx = 1'b1;
    cfg.anySourceEnabled = 1'b1;
    cfg.thermalPrewarnEnable = 1'b1;
    tick(8);
    devIs(DEV_OFF);
    check("canRxd", 8'(canRxd), 8'h01);
    rst <= 1'b0;
    tick(12);
    devIs(DEV_STANDBY);
    canIs(CAN_STBY);
    rd(DEV_CTRL_ADDR, DEV_CTRL_RESET);
    rd(DEV_STATUS_ADDR, 8'h21);
    env.thermalHigh <= 1'b1;
    tick(6);
    rd(DEV_STATUS_ADDR, 8'h61);
    cfg.thermalPrewarnEnable <= 1'b0;
    env.thermalHigh <= 1'b0;
    tick(6);
    rd(DEV_STATUS_ADDR, 8'h61);
    cfg.thermalPrewarnEnable <= 1'b1;
    wr(DEV_STATUS_ADDR, 8'hFF);
    rd(DEV_STATUS_ADDR, 8'h21);
    wr(DEV_CTRL_ADDR, 8'hE4);
    rd(DEV_CTRL_ADDR, 8'h24);
    rd(7'h10, 8'h00);
    env.busDominant <= 1'b1;
    tick(10);
    canIs(CAN_BIASED);
    env.busDominant <= 1'b0;
    tick(12);
    canIs(CAN_BIASED);
    tick(20);
    canIs(CAN_STBY);
    wup();
    check("wakeFlags", 8'(wakeFlags), 8'h00);
    check("canRxd", 8'(canRxd), 8'h01);
    cfg.canWakeEnable <= 1'b1;
    wup();
    check("wakeFlags", 8'(wakeFlags), 8'h01);
    check("canRxd", 8'(canRxd), 8'h00);
    clr();
    cfg.canWakeEnable <= 1'b0;
    wr(DEV_CTRL_ADDR, 8'h27);
    devIs(DEV_NORMAL);
    rd(DEV_STATUS_ADDR, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(CAN_CTRL_ADDR, {6'h10, copmTab[i]});
      canIs(canTab[i]);
    end
    env.linStandby <= 1'b1;
    env.linWake <= 1'b1;
    env.interruptEvent <= 1'b1;
    tick(6);
    env.linWake <= 1'b0;
    env.interruptEvent <= 1'b0;
    tick(4);
    check("wakeFlags", 8'(wakeFlags), 8'h06);
    clr();
    wr(DEV_CTRL_ADDR, 8'h22);
    devIs(DEV_STANDBY);
    wr(DEV_CTRL_ADDR, 8'h21);
    devIs(DEV_SLEEP);
    check("regulatorOn", 8'(regulatorOn), 8'h00);
    rd(DEV_STATUS_ADDR, 8'h01);
    pulse(WAKE_LOCAL);
    devIs(DEV_RESET);
    canIs(CAN_STBY);
    tick(RESET_CYCLES);
    devIs(DEV_STANDBY);
    wr(DEV_CTRL_ADDR, 8'h01);
    pulse(WAKE_INT);
    devIs(DEV_STANDBY);
    wr(DEV_CTRL_ADDR, 8'h14);
    env.vccOvervolt <= 1'b1;
    tick(6);
    devIs(DEV_SLEEP);
    env.vccOvervolt <= 1'b0;
    rd(DEV_STATUS_ADDR, 8'h81);
    pulse(WAKE_LOCAL);
    devIs(DEV_STANDBY);
    check("regulatorOn", 8'(regulatorOn), 8'h01);
    // another wake source stays enabled while the aux option is on
    wr(DEV_CTRL_ADDR, 8'h09);
    env.auxUndervolt <= 1'b1;
    tick(6);
    devIs(DEV_RESET);
    env.auxUndervolt <= 1'b0;
    tick(RESET_CYCLES + 6);
    devIs(DEV_STANDBY);
    wr(DEV_CTRL_ADDR, 8'h01);
    env.auxUndervolt <= 1'b1;
    tick(6);
    devIs(DEV_SLEEP);
    rd(DEV_STATUS_ADDR, 8'h01);
    cfg.externalWakeEnable <= 1'b1;
    env.auxUndervolt <= 1'b0;
    tick(6);
    devIs(DEV_STANDBY);
    env.vsUvTrx <= 1'b1;
    tick(6);
    canIs(CAN_OFF);
    check("canRxd", 8'(canRxd), 8'h01);
    env.vsUvTrx <= 1'b0;
    tick(6);
    canIs(CAN_STBY);
    // overtemperature off; restart waits for the temperature hysteresis
    env.canOvertemp <= 1'b1;
    env.canTempOk <= 1'b0;
    tick(6);
    canIs(CAN_OFF);
    env.canOvertemp <= 1'b0;
    tick(6);
    canIs(CAN_OFF);
    env.canTempOk <= 1'b1;
    tick(6);
    canIs(CAN_STBY);
    env.vsPowerOk <= 1'b0;
    tick(6);
    devIs(DEV_OFF);
    results();
  end

  // whole sequence needs roughly 5k cycles
  initial begin
    tick(40000);
    failCount++;
    results();
  end
endmodule : device_can_mode_control_test
